// File: verilog/uimt_pkg.sv
// constants and types shared by the interrupt mask and tx dma register bank
package uimt_pkg;
    localparam int unsigned uimt_aw = 8;
    // register byte offsets
    localparam logic [7:0] uimt_off_src_raw = 8'h00;
    localparam logic [7:0] uimt_off_src_set = 8'h04;
    localparam logic [7:0] uimt_off_src_clr = 8'h08;
    localparam logic [7:0] uimt_off_mask = 8'h0c;
    localparam logic [7:0] uimt_off_mask_set = 8'h10;
    localparam logic [7:0] uimt_off_mask_clr = 8'h14;
    localparam logic [7:0] uimt_off_masked = 8'h18;
    localparam logic [7:0] uimt_off_eoi = 8'h1c;
    localparam logic [7:0] uimt_off_txctl = 8'h20;
    localparam logic [7:0] uimt_off_txtd = 8'h24;
    localparam logic [7:0] uimt_off_evst = 8'h28;
    localparam logic [7:0] uimt_off_evmask = 8'h2c;
    // field layout of source, mask and masked registers
    localparam logic [31:0] uimt_src_fields = 32'h01ff_1e1f;
    localparam int unsigned uimt_td_ready_bit = 31;
    localparam int unsigned uimt_td_chan_lsb = 0;
    localparam int unsigned uimt_td_chan_w = 2;
    localparam int unsigned uimt_txen_bit = 0;
    localparam int unsigned uimt_eoi_w = 8;
    // reset values
    localparam logic [31:0] uimt_rst_mask = 32'h0000_0000;
    localparam logic [7:0] uimt_rst_eoi = 8'h00;
    localparam logic [2:0] uimt_rst_evmask = 3'h0;
    // event status bits
    localparam int unsigned uimt_ev_eoi = 0;
    localparam int unsigned uimt_ev_td_done = 1;
    localparam int unsigned uimt_ev_src = 2;
    localparam int unsigned uimt_ev_w = 3;

    typedef enum logic [1:0] {
        uimt_td_idle = 2'b00,
        uimt_td_busy = 2'b01
    } uimt_td_state_t;
endpackage

// File: verilog/uimt_td_if.sv
// carries teardown requests between the bank and the teardown sequencer
`timescale 1ns/1ps
`default_nettype none
interface uimt_td_if;
    logic req;
    logic [1:0] chan;
    logic ready;
    logic done;
    modport bank (output req, output chan, input ready, input done);
    modport seq (input req, input chan, output ready, output done);
endinterface
`default_nettype wire

// File: verilog/uimt_td_seq.sv
// teardown sequencer: holds a channel request until the dma acknowledges
`timescale 1ns/1ps
`default_nettype none
module uimt_td_seq
    import uimt_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    uimt_td_if.seq td,
    output logic [1:0] td_chan,
    output logic td_start,
    input wire logic td_ack
);
    import uimt_pkg::*;

    typedef struct packed {
        uimt_td_state_t st;
        logic [1:0] chan;
        logic start;
        logic done;
    } uimt_seq_state_t;

    uimt_seq_state_t s_r;
    uimt_seq_state_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.start = 1'b0;
        s_nxt.done = 1'b0;
        case (s_r.st)
            uimt_td_idle: begin
                if (td.req) begin
                    s_nxt.chan = td.chan;
                    s_nxt.start = 1'b1;
                    s_nxt.st = uimt_td_busy;
                end
            end
            uimt_td_busy: begin
                if (td_ack) begin
                    s_nxt.done = 1'b1;
                    s_nxt.st = uimt_td_idle;
                end
            end
            default: s_nxt.st = uimt_td_idle;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ready only while no teardown is outstanding
    assign td.ready = (s_r.st == uimt_td_idle);
    assign td.done = s_r.done;
    assign td_chan = s_r.chan;
    assign td_start = s_r.start;
endmodule // uimt_td_seq
`default_nettype wire

// File: verilog/uimt_regs.sv
// apb register bank: usb irq mask, masked status, eoi, tx dma control
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - mask-set core bits 24:16 enable mask
// - mask-set rx bits 12:9 enable mask
// - mask-set tx bits 4:0 enable mask
// - mask-clear core bits 24:16 disable mask
// - mask-clear rx bits 12:9 disable mask
// - mask-clear tx bits 4:0 disable mask
// - masked status is raw AND mask
// - eoi write of zero acknowledges core irq
// - tx dma control bit 0 enables dma
// - teardown bit 31 shows write acceptance
// - teardown bits 1:0 select channel
// - source-clear write of one clears source unless its synchronised event is still high
// - raw layout 24:16, 12:9, 4:0
module uimt_regs
    import uimt_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [uimt_pkg::uimt_aw-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [31:0] core_irq_events,
    output logic core_irq_eoi,
    output logic usb_irq,
    output logic tx_dma_enable,
    output logic [1:0] td_chan,
    output logic td_start,
    input wire logic td_ack,
    output logic irq
);
    import uimt_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [31:0] raw;
        logic [31:0] mask;
        logic [7:0] eoi;
        logic txen;
        logic eoi_pulse;
        logic [uimt_ev_w-1:0] evst;
        logic [uimt_ev_w-1:0] evmask;
        logic [31:0] rdata;
    } uimt_regs_state_t;

    uimt_regs_state_t s_r;
    uimt_regs_state_t s_nxt;
    uimt_td_if td();

    logic [31:0] ev_sync1_r;
    logic [31:0] ev_sync2_r;
    logic wr_en;
    logic rd_en;
    logic mapped;
    logic [31:0] masked;

    function automatic logic [31:0] fld(input logic [31:0] v);
        fld = v & uimt_src_fields;
    endfunction

    uimt_td_seq u_seq (
        .pclk(pclk),
        .presetn(presetn),
        .td(td.seq),
        .td_chan(td_chan),
        .td_start(td_start),
        .td_ack(td_ack)
    );

    ////////////////////////////////////////////////////////////////////////
    // core sources arrive from another clock region
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_sync1_r <= 32'h0000_0000;
            ev_sync2_r <= 32'h0000_0000;
        end else begin
            ev_sync1_r <= core_irq_events;
            ev_sync2_r <= ev_sync1_r;
        end
    end

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign masked = fld(s_r.raw & s_r.mask);
    assign pready = 1'b1;

    always_comb begin
        case (paddr)
            uimt_off_src_raw, uimt_off_src_set, uimt_off_src_clr,
            uimt_off_mask, uimt_off_mask_set, uimt_off_mask_clr,
            uimt_off_masked, uimt_off_eoi, uimt_off_txctl,
            uimt_off_txtd, uimt_off_evst, uimt_off_evmask: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !mapped;

    // teardown request only taken while the sequencer is idle
    assign td.req = wr_en && (paddr == uimt_off_txtd) && td.ready;
    assign td.chan = pwdata[uimt_td_chan_lsb +: uimt_td_chan_w];

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [31:0] clr;
        logic [uimt_ev_w-1:0] ev_set;
        clr = 32'h0000_0000;
        ev_set = '0;
        s_nxt = s_r;
        s_nxt.eoi_pulse = 1'b0;
        // source set pulses are taken from the synchronised edge
        ev_set[uimt_ev_src] = |fld(ev_sync2_r & ~s_r.raw);
        ev_set[uimt_ev_td_done] = td.done;
        if (wr_en) begin
            case (paddr)
                uimt_off_src_set: s_nxt.raw = s_r.raw | fld(pwdata);
                uimt_off_src_clr: clr = fld(pwdata);
                uimt_off_mask_set:
                    s_nxt.mask = s_r.mask | fld(pwdata);
                uimt_off_mask_clr:
                    s_nxt.mask = s_r.mask & ~fld(pwdata);
                uimt_off_eoi: begin
                    s_nxt.eoi = pwdata[uimt_eoi_w-1:0];
                    if (pwdata[uimt_eoi_w-1:0] == 8'h00) begin
                        s_nxt.eoi_pulse = 1'b1;
                        ev_set[uimt_ev_eoi] = 1'b1;
                    end
                end
                uimt_off_txctl: s_nxt.txen = pwdata[uimt_txen_bit];
                uimt_off_evmask: s_nxt.evmask = pwdata[uimt_ev_w-1:0];
                default: ;
            endcase
        end
        // a new source event wins over a simultaneous clear
        s_nxt.raw = fld((s_nxt.raw & ~clr) | ev_sync2_r);
        // read-to-clear of event status; new events still land
        if (rd_en && paddr == uimt_off_evst) begin
            s_nxt.evst = ev_set;
        end else begin
            s_nxt.evst = s_r.evst | ev_set;
        end
        if (rd_en) begin
            case (paddr)
                uimt_off_src_raw: s_nxt.rdata = s_r.raw;
                uimt_off_mask: s_nxt.rdata = s_r.mask;
                uimt_off_masked: s_nxt.rdata = masked;
                uimt_off_eoi: s_nxt.rdata = {24'h00_0000, s_r.eoi};
                uimt_off_txctl: s_nxt.rdata = {31'h0000_0000, s_r.txen};
                uimt_off_txtd:
                    s_nxt.rdata = {td.ready, 29'h0000_0000,
                        td_chan};
                uimt_off_evst: s_nxt.rdata = {29'h0000_0000, s_r.evst};
                uimt_off_evmask: s_nxt.rdata = {29'h0000_0000, s_r.evmask};
                default: s_nxt.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
            s_r.mask <= uimt_rst_mask;
            s_r.eoi <= uimt_rst_eoi;
            s_r.evmask <= uimt_rst_evmask;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign prdata = s_r.rdata;
    assign core_irq_eoi = s_r.eoi_pulse;
    assign usb_irq = |masked;
    // gating by software is expected from the dma, not forced here
    assign tx_dma_enable = s_r.txen;
    assign irq = |(s_r.evst & s_r.evmask);
endmodule // uimt_regs
`default_nettype wire

// File: dv/uimt_regs_asserts.sv
// port assertions for the usb irq mask and tx dma register bank
`timescale 1ns/1ps
`default_nettype none
module uimt_regs_asserts
    import uimt_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic core_irq_eoi,
    input wire logic tx_dma_enable,
    input wire logic [1:0] td_chan,
    input wire logic td_start
);
    wire wr = psel && penable && pwrite;
    wire eoi0 = wr && paddr == uimt_off_eoi && pwdata[7:0] == 8'h00;
    wire txw = wr && paddr == uimt_off_txctl;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_high: assert property (pready) else $error("pready low");
    a_err_unmapped: assert property (pslverr == (psel && penable
        && (paddr > uimt_off_evmask || paddr[1:0] != 2'b00)))
        else $error("pslverr wrong");
    a_eoi_pulse: assert property (eoi0 |=> core_irq_eoi)
        else $error("eoi pulse missing");
    a_eoi_cause: assert property (core_irq_eoi |-> $past(eoi0))
        else $error("eoi pulse stray");
    a_txen_write: assert property (txw |=>
        tx_dma_enable == $past(pwdata[0]))
        else $error("txen not written");
    a_txen_hold: assert property (!txw |=> $stable(tx_dma_enable))
        else $error("txen moved");
    a_td_cause: assert property (td_start |->
        $past(wr && paddr == uimt_off_txtd))
        else $error("td start stray");
    a_td_chan: assert property (td_start |->
        td_chan == $past(pwdata[1:0]))
        else $error("td chan wrong");
    a_td_single: assert property (td_start |=> !td_start)
        else $error("td start long");
    cover property (core_irq_eoi);
    cover property (td_start);
    cover property (txw ##1 tx_dma_enable);
endmodule // uimt_regs_asserts
bind uimt_regs uimt_regs_asserts uimt_regs_asserts_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .core_irq_eoi(core_irq_eoi), .tx_dma_enable(tx_dma_enable),
    .td_chan(td_chan), .td_start(td_start));
`default_nettype wire

// File: dv/test_usb_irq_mask_tx_dma_ctrl_regs.sv
// self-checking bench for the usb irq mask and tx dma register bank
`timescale 1ns/1ps
`default_nettype none
module test_usb_irq_mask_tx_dma_ctrl_regs;
    import uimt_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, td_ack = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, core_irq_events = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, core_irq_eoi, usb_irq, tx_dma_enable;
    logic td_start, irq, err;
    logic [1:0] td_chan;
    int n_mismatch = 0, n_compared = 0;
    uimt_regs uimt_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .core_irq_events(core_irq_events), .core_irq_eoi(core_irq_eoi),
        .usb_irq(usb_irq), .tx_dma_enable(tx_dma_enable), .td_chan(td_chan),
        .td_start(td_start), .td_ack(td_ack), .irq(irq));
    initial begin
        forever #25 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t word %h expected %h", $time, got, exp);
        end
    endtask
    // flags are copied when the task is called; the compare runs after the falling edge
    task automatic chk_bit(input logic got, input logic exp);
        @(negedge pclk);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t flag %b expected %b", $time, got, exp);
        end
        @(posedge pclk);
    endtask
    task automatic close_out;
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk_word(rd, exp);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rdc(uimt_off_mask, uimt_rst_mask);
        rdc(uimt_off_txtd, 32'h8000_0000);
        rdc(uimt_off_txctl, 32'h0000_0000);
    endtask
    task automatic t_mask;
        apb(1'b1, uimt_off_mask_set, 32'hffff_ffff);
        rdc(uimt_off_mask, uimt_src_fields);
        apb(1'b1, uimt_off_mask_clr, 32'h0100_0201);
        rdc(uimt_off_mask, 32'h00ff_1c1e);
        apb(1'b1, uimt_off_mask_set, 32'h0000_0000);
        apb(1'b1, uimt_off_mask_clr, 32'h0000_0000);
        rdc(uimt_off_mask, 32'h00ff_1c1e);
    endtask
    task automatic t_status;
        core_irq_events <= 32'hffff_ffff;
        repeat (4) @(posedge pclk);
        rdc(uimt_off_src_raw, uimt_src_fields);
        rdc(uimt_off_masked, 32'h00ff_1c1e);
        chk_bit(usb_irq, 1'b1);
        apb(1'b1, uimt_off_mask_clr, 32'hffff_ffff);
        rdc(uimt_off_masked, 32'h0000_0000);
        chk_bit(usb_irq, 1'b0);
        core_irq_events <= 32'h0000_0000;
        repeat (4) @(posedge pclk);
        apb(1'b1, uimt_off_src_clr, 32'h0001_0001);
        rdc(uimt_off_src_raw, 32'h01fe_1e1e);
    endtask
    task automatic t_irq;
        apb(1'b0, uimt_off_evst, 32'h0000_0000);
        apb(1'b1, uimt_off_evmask, 32'h0000_0000);
        apb(1'b1, uimt_off_eoi, 32'h0000_005a);
        rdc(uimt_off_eoi, 32'h0000_005a);
        rdc(uimt_off_evst, 32'h0000_0000);
        apb(1'b1, uimt_off_eoi, 32'h0000_0000);
        chk_bit(irq, 1'b0);
        apb(1'b1, uimt_off_evmask, 32'h0000_0001);
        chk_bit(irq, 1'b1);
        rdc(uimt_off_evst, 32'h0000_0001);
        chk_bit(irq, 1'b0);
    endtask
    task automatic t_txen;
        // no descriptors to prepare here, so enabling at once is legal
        apb(1'b1, uimt_off_txctl, 32'h0000_0001);
        rdc(uimt_off_txctl, 32'h0000_0001);
        chk_bit(tx_dma_enable, 1'b1);
        apb(1'b1, uimt_off_txctl, 32'hffff_fffe);
        rdc(uimt_off_txctl, 32'h0000_0000);
        chk_bit(tx_dma_enable, 1'b0);
    endtask
    task automatic t_td;
        for (int c = 0; c < 4; c++) begin
            // ready was read back as one before each first request
            apb(1'b1, uimt_off_txtd, 32'(c));
            // second request while busy must be refused
            apb(1'b1, uimt_off_txtd, 32'((c + 1) % 4));
            rdc(uimt_off_txtd, 32'(c));
            chk_word({30'h0, td_chan}, 32'(c));
            td_ack <= 1'b1;
            @(posedge pclk);
            td_ack <= 1'b0;
            repeat (2) @(posedge pclk);
            rdc(uimt_off_txtd, 32'h8000_0000 | 32'(c));
        end
    endtask
    task automatic t_unmapped;
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk_word(rd, 32'h0000_0000);
        chk_bit(err, 1'b1);
        apb(1'b1, 8'h30, 32'hffff_ffff);
        rdc(uimt_off_mask, 32'h0000_0000);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_mask;
        t_status;
        t_irq;
        t_txen;
        t_td;
        t_unmapped;
        close_out;
    end
    // whole run needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge pclk);
        n_mismatch++;
        close_out;
    end
endmodule // test_usb_irq_mask_tx_dma_ctrl_regs
`default_nettype wire
